/* hw/cmc_ctrl_cell.sv */
`timescale 1ns/100ps
module cmc_ctrl_cell
  import cmc_pkg::*;
#(
  parameter bit RX_ONLY = 1'b0
) (
  input logic i_clk,
  input logic i_reset,
  input logic i_wr,
  input logic [7:0] i_wdata,
  input logic i_dir_tx,
  input cmc_event_type i_evt,
  output cmc_ctrl_type o_ctrl,
  output logic o_tx_enable
);

  cmc_ctrl_type ctrl_r;
  cmc_ctrl_type ctrl_nxt;
  cmc_ctrl_type wr_val;
  logic dir_tx;

  // A receive-only center never sees transmit mode, so its inhibit is ignored
  assign dir_tx = i_dir_tx & ~RX_ONLY;

  always_comb begin
    wr_val = cmc_ctrl_type'(i_wdata);
    ctrl_nxt = ctrl_r;
    if (i_wr) begin
      ctrl_nxt.message_ready = wr_val.message_ready;
      ctrl_nxt.transmit_int_enable = wr_val.transmit_int_enable;
      ctrl_nxt.receive_int_enable = wr_val.receive_int_enable;
      ctrl_nxt.interrupt_request = wr_val.interrupt_request;
      // Software can only clear this one
      ctrl_nxt.external_request = ctrl_r.external_request & wr_val.external_request;
      ctrl_nxt.transmit_request = wr_val.transmit_request;
      ctrl_nxt.data_updated = wr_val.data_updated;
      if (dir_tx) begin
        ctrl_nxt.transmit_inhibit = wr_val.transmit_inhibit;
      end else if (ctrl_r.data_updated && !wr_val.data_updated) begin
        ctrl_nxt.transmit_inhibit = 1'b0;
      end
    end
    // Engine events come last so a set beats a same-cycle software clear
    if (i_evt.rx_stored && !dir_tx) begin
      if (ctrl_r.data_updated) begin
        ctrl_nxt.transmit_inhibit = 1'b1;
      end
      ctrl_nxt.data_updated = 1'b1;
      if (ctrl_r.receive_int_enable) begin
        ctrl_nxt.interrupt_request = 1'b1;
      end
    end
    if (i_evt.tx_done) begin
      // Data-updated is left alone after a send
      ctrl_nxt.transmit_request = 1'b0;
      if (ctrl_r.transmit_int_enable && dir_tx) begin
        ctrl_nxt.interrupt_request = 1'b1;
      end
    end
    if (i_evt.remote_req) begin
      ctrl_nxt.external_request = 1'b1;
      if (dir_tx) begin
        ctrl_nxt.transmit_request = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= cmc_ctrl_type'(CMC_CTRL_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign o_ctrl = ctrl_r;
  // Remote frames in receive mode are gated only by ready and request
  assign o_tx_enable = ctrl_r.message_ready & ctrl_r.transmit_request
                       & ~(dir_tx & ctrl_r.transmit_inhibit);

endmodule

/* hw/cmc_msg_ctrl_regs.sv */
// Function
// - Control byte: ready, tx int en, rx int en, irq, ext req, tx req, inhibit, updated
// - Reset clears every bit of every control register, centers 6 to 15
// - Upper four bits read/write; external request clear only; low three special
// - Each center's register behaves like center one's, for its own center, except center 15, which receives only
// - Decode F3h-F7h, FBh-FEh and FFh for centers 6 to 15
// - Priority register bit 7 picks low or high CAN activity priority
// - Successful send clears transmit request and leaves data updated set
// - Stored received message sets data updated
// - Store while updated set flags overwrite; clearing updated clears it
// - Inhibit set in transmit direction blocks sending for that center
`timescale 1ns/100ps
module cmc_msg_ctrl_regs
  import cmc_pkg::*;
#(
  parameter int NUM_CENTERS = CMC_NUM_CENTERS
) (
  input logic i_clk,
  input logic i_reset,
  input cmc_sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_rvalid,
  output logic o_sfr_hit,
  input logic [NUM_CENTERS-1:0] i_dir_tx,
  input cmc_event_type [NUM_CENTERS-1:0] i_evt,
  output cmc_ctrl_type [NUM_CENTERS-1:0] o_ctrl,
  output logic [NUM_CENTERS-1:0] o_tx_enable,
  output logic o_can_activity_priority
);

  // The address map is fixed, so no other count can be served
  if (NUM_CENTERS != CMC_NUM_CENTERS) begin : g_bad_count
    $error("NUM_CENTERS must match the fixed address map");
  end

  typedef struct packed {
    logic [7:0] extended_irq_priority;
    logic [7:0] rdata;
    logic rvalid;
  } cmc_top_state_type;

  cmc_top_state_type st_r;
  cmc_top_state_type st_nxt;
  logic [4:0] dec;
  logic ctr_hit;
  logic [3:0] ctr_idx;
  logic eip_hit;
  logic [NUM_CENTERS-1:0] wr_sel;

  // Returns {hit, index} for a control register address
  function automatic logic [4:0] center_of(input logic [7:0] addr);
    logic [4:0] res;
    res = 5'h00;
    unique case (addr)
      CMC_ADDR_MC06: res = {1'b1, 4'h0};
      CMC_ADDR_MC07: res = {1'b1, 4'h1};
      CMC_ADDR_MC08: res = {1'b1, 4'h2};
      CMC_ADDR_MC09: res = {1'b1, 4'h3};
      CMC_ADDR_MC10: res = {1'b1, 4'h4};
      CMC_ADDR_MC11: res = {1'b1, 4'h5};
      CMC_ADDR_MC12: res = {1'b1, 4'h6};
      CMC_ADDR_MC13: res = {1'b1, 4'h7};
      CMC_ADDR_MC14: res = {1'b1, 4'h8};
      CMC_ADDR_MC15: res = {1'b1, 4'h9};
      default: res = 5'h00;
    endcase
    return res;
  endfunction

  assign dec = center_of(i_sfr.addr);
  assign ctr_hit = dec[4];
  assign ctr_idx = dec[3:0];
  assign eip_hit = (i_sfr.addr == CMC_ADDR_EIP);
  assign o_sfr_hit = ctr_hit | eip_hit;

  for (genvar g = 0; g < NUM_CENTERS; g++) begin : g_center
    assign wr_sel[g] = i_sfr.wr & ctr_hit & (ctr_idx == 4'(g));

    // Same cell for every center; only center 15 gets the receive-only setting
    cmc_ctrl_cell #(
      .RX_ONLY(4'(g) == CMC_RX_ONLY_INDEX)
    ) u_cell (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_wr(wr_sel[g]),
      .i_wdata(i_sfr.wdata),
      .i_dir_tx(i_dir_tx[g]),
      .i_evt(i_evt[g]),
      .o_ctrl(o_ctrl[g]),
      .o_tx_enable(o_tx_enable[g])
    );

    AST_RESET_CLEARS: assert property (
      @(posedge i_clk) i_reset |=> (o_ctrl[g] == cmc_ctrl_type'(CMC_CTRL_RESET))
    ) else $error("control register not zero after reset");

    AST_UPPER_RW: assert property (
      @(posedge i_clk) disable iff (i_reset)
      wr_sel[g] |=> (o_ctrl[g][7:5] == $past(i_sfr.wdata[7:5]))
    ) else $error("upper control bits did not take written value");

    AST_EXT_CLEAR_ONLY: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && !o_ctrl[g].external_request && !i_evt[g].remote_req)
      |=> !o_ctrl[g].external_request
    ) else $error("software managed to set external request");

    AST_TX_DONE: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].tx_done && !i_evt[g].remote_req && o_ctrl[g].data_updated && !wr_sel[g])
      |=> (!o_ctrl[g].transmit_request && o_ctrl[g].data_updated)
    ) else $error("send completion handled wrongly");

    AST_RX_UPDATED: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].rx_stored && !i_dir_tx[g]) |=> o_ctrl[g].data_updated
    ) else $error("received message did not set data updated");

    AST_OVERWRITE_SET: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].rx_stored && !i_dir_tx[g] && o_ctrl[g].data_updated)
      |=> o_ctrl[g].transmit_inhibit
    ) else $error("overwrite not flagged");

    AST_OVERWRITE_CLR: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && !i_dir_tx[g] && o_ctrl[g].data_updated && !i_sfr.wdata[0]
       && !i_evt[g].rx_stored)
      |=> (!o_ctrl[g].transmit_inhibit && !o_ctrl[g].data_updated)
    ) else $error("overwrite not cleared with data updated");

    AST_INHIBIT_BLOCKS: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_dir_tx[g] && o_ctrl[g].transmit_inhibit && (4'(g) != CMC_RX_ONLY_INDEX))
      |-> !o_tx_enable[g]
    ) else $error("inhibited center enabled to send");

    AST_SET_BEATS_CLEAR: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && !i_sfr.wdata[3] && i_evt[g].remote_req) |=> o_ctrl[g].external_request
    ) else $error("engine set lost to software clear");

    AST_TX_EN_NEEDS_REQ: assert property (
      @(posedge i_clk) disable iff (i_reset)
      o_tx_enable[g] |-> (o_ctrl[g].message_ready && o_ctrl[g].transmit_request)
    ) else $error("center enabled to send without ready and request");

    AST_TX_EN_UNBLOCKED: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (o_ctrl[g].message_ready && o_ctrl[g].transmit_request
       && !(i_dir_tx[g] && o_ctrl[g].transmit_inhibit))
      |-> o_tx_enable[g]
    ) else $error("ready center not enabled to send");

    AST_INHIBIT_RW: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && i_dir_tx[g] && (4'(g) != CMC_RX_ONLY_INDEX))
      |=> (o_ctrl[g].transmit_inhibit == $past(i_sfr.wdata[CMC_BIT_TRANSMIT_INHIBIT]))
    ) else $error("inhibit did not take written value");

    AST_OVERWRITE_RO: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && !i_dir_tx[g] && i_sfr.wdata[0] && !i_evt[g].rx_stored)
      |=> (o_ctrl[g].transmit_inhibit == $past(o_ctrl[g].transmit_inhibit))
    ) else $error("software changed the overwrite flag");

    AST_NO_OVERWRITE_WHEN_READ: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].rx_stored && !i_dir_tx[g] && !o_ctrl[g].data_updated)
      |=> (o_ctrl[g].transmit_inhibit == $past(o_ctrl[g].transmit_inhibit))
    ) else $error("overwrite flagged although data was read");

    AST_LOW_BITS_RW: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && i_evt[g] == '0)
      |=> (o_ctrl[g].transmit_request == $past(i_sfr.wdata[2])
           && o_ctrl[g].data_updated == $past(i_sfr.wdata[0]))
    ) else $error("request or updated bit did not take written value");

    AST_IRQ_RW: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && i_evt[g] == '0)
      |=> (o_ctrl[g].interrupt_request == $past(i_sfr.wdata[4]))
    ) else $error("interrupt request did not take written value");

    AST_EXT_CLEARED: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && !i_sfr.wdata[3] && !i_evt[g].remote_req) |=> !o_ctrl[g].external_request
    ) else $error("software clear of external request lost");

    AST_EXT_KEPT: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (wr_sel[g] && i_sfr.wdata[3] && o_ctrl[g].external_request)
      |=> o_ctrl[g].external_request
    ) else $error("external request lost on write of one");

    AST_RX_IRQ: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].rx_stored && !i_dir_tx[g] && o_ctrl[g].receive_int_enable)
      |=> o_ctrl[g].interrupt_request
    ) else $error("receive did not raise interrupt request");

    AST_TX_IRQ: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].tx_done && i_dir_tx[g] && (4'(g) != CMC_RX_ONLY_INDEX)
       && o_ctrl[g].transmit_int_enable)
      |=> o_ctrl[g].interrupt_request
    ) else $error("send did not raise interrupt request");

    AST_REMOTE_EXT: assert property (
      @(posedge i_clk) disable iff (i_reset)
      i_evt[g].remote_req |=> o_ctrl[g].external_request
    ) else $error("remote request not flagged");

    AST_REMOTE_TX: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].remote_req && i_dir_tx[g] && (4'(g) != CMC_RX_ONLY_INDEX))
      |=> o_ctrl[g].transmit_request
    ) else $error("remote request did not queue a send");

    AST_RX_ONLY_STORES: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (i_evt[g].rx_stored && (4'(g) == CMC_RX_ONLY_INDEX)) |=> o_ctrl[g].data_updated
    ) else $error("receive-only center ignored a stored message");

    AST_UPDATED_STICKY: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (o_ctrl[g].data_updated && !wr_sel[g]) |=> o_ctrl[g].data_updated
    ) else $error("data updated cleared without software");

    AST_HOLD_IDLE: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (!wr_sel[g] && i_evt[g] == '0) |=> (o_ctrl[g] == $past(o_ctrl[g]))
    ) else $error("control register changed with no write or event");
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = i_sfr.rd;
    if (i_sfr.wr && eip_hit) begin
      st_nxt.extended_irq_priority = i_sfr.wdata;
    end
    if (i_sfr.rd) begin
      if (ctr_hit) begin
        st_nxt.rdata = o_ctrl[ctr_idx];
      end else if (eip_hit) begin
        st_nxt.rdata = st_r.extended_irq_priority;
      end else begin
        // Unmapped addresses read as zero
        st_nxt.rdata = CMC_READ_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r.extended_irq_priority <= CMC_EIP_RESET;
      st_r.rdata <= CMC_READ_IDLE;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sfr_rdata = st_r.rdata;
  assign o_sfr_rvalid = st_r.rvalid;
  assign o_can_activity_priority = st_r.extended_irq_priority[CMC_BIT_CAN_ACTIVITY_PRIORITY];

  AST_PRIORITY: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_sfr.wr && i_sfr.addr == CMC_ADDR_EIP) |=> (o_can_activity_priority == $past(i_sfr.wdata[7]))
  ) else $error("activity priority not written");

  AST_READ_MC15: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_sfr.rd && i_sfr.addr == CMC_ADDR_MC15)
    |=> (o_sfr_rvalid && o_sfr_rdata == $past(o_ctrl[NUM_CENTERS-1]))
  ) else $error("center 15 read returned wrong byte");

  AST_HIT_DECODE: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_sfr_hit == ((i_sfr.addr >= CMC_ADDR_MC06 && i_sfr.addr <= CMC_ADDR_EIP)
                  || i_sfr.addr >= CMC_ADDR_MC11)
  ) else $error("address decode hit wrong");

  AST_RVALID_ON_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_sfr.rd |=> o_sfr_rvalid
  ) else $error("read not answered");

  AST_RVALID_ONE_CYCLE: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_sfr.rd |=> !o_sfr_rvalid
  ) else $error("read valid without a read");

  AST_READ_UNMAPPED: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_sfr.rd && !o_sfr_hit) |=> (o_sfr_rdata == CMC_READ_IDLE)
  ) else $error("unmapped read returned nonzero");

  AST_RDATA_HOLD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_sfr.rd |=> (o_sfr_rdata == $past(o_sfr_rdata))
  ) else $error("read data changed without a read");

  AST_READ_EIP: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_sfr.rd && i_sfr.addr == CMC_ADDR_EIP)
    |=> (o_sfr_rdata[CMC_BIT_CAN_ACTIVITY_PRIORITY] == $past(o_can_activity_priority))
  ) else $error("priority register read back wrong");

  AST_PRIORITY_HOLD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !(i_sfr.wr && i_sfr.addr == CMC_ADDR_EIP)
    |=> (o_can_activity_priority == $past(o_can_activity_priority))
  ) else $error("activity priority changed without a write");

endmodule

/* hw/cmc_pkg.sv */
package cmc_pkg;

  // Message centers 6 through 15 of the second CAN controller
  localparam int CMC_NUM_CENTERS = 10;

  // Special-function addresses
  localparam logic [7:0] CMC_ADDR_MC06 = 8'hf3;
  localparam logic [7:0] CMC_ADDR_MC07 = 8'hf4;
  localparam logic [7:0] CMC_ADDR_MC08 = 8'hf5;
  localparam logic [7:0] CMC_ADDR_MC09 = 8'hf6;
  localparam logic [7:0] CMC_ADDR_MC10 = 8'hf7;
  localparam logic [7:0] CMC_ADDR_EIP = 8'hf8;
  localparam logic [7:0] CMC_ADDR_MC11 = 8'hfb;
  localparam logic [7:0] CMC_ADDR_MC12 = 8'hfc;
  localparam logic [7:0] CMC_ADDR_MC13 = 8'hfd;
  localparam logic [7:0] CMC_ADDR_MC14 = 8'hfe;
  localparam logic [7:0] CMC_ADDR_MC15 = 8'hff;

  // Control register field positions
  localparam int CMC_BIT_MESSAGE_READY = 7;
  localparam int CMC_BIT_TRANSMIT_INT_ENABLE = 6;
  localparam int CMC_BIT_RECEIVE_INT_ENABLE = 5;
  localparam int CMC_BIT_INTERRUPT_REQUEST = 4;
  localparam int CMC_BIT_EXTERNAL_REQUEST = 3;
  localparam int CMC_BIT_TRANSMIT_REQUEST = 2;
  localparam int CMC_BIT_TRANSMIT_INHIBIT = 1;
  localparam int CMC_BIT_DATA_UPDATED = 0;

  // Extended interrupt priority field position
  localparam int CMC_BIT_CAN_ACTIVITY_PRIORITY = 7;

  // Reset values
  localparam logic [7:0] CMC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CMC_EIP_RESET = 8'h00;
  localparam logic [7:0] CMC_READ_IDLE = 8'h00;

  // Index of a center that receives only
  localparam logic [3:0] CMC_RX_ONLY_INDEX = 4'h9;

  // Bit 1 is overwrite flag in receive direction, inhibit in transmit
  typedef struct packed {
    logic message_ready;
    logic transmit_int_enable;
    logic receive_int_enable;
    logic interrupt_request;
    logic external_request;
    logic transmit_request;
    logic transmit_inhibit;
    logic data_updated;
  } cmc_ctrl_type;

  // One-cycle pulses from the protocol engine, per center
  typedef struct packed {
    logic tx_done;
    logic rx_stored;
    logic remote_req;
  } cmc_event_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cmc_sfr_req_type;

endpackage

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import cmc_pkg::*;
  logic i_clk;
  logic i_reset;
  cmc_sfr_req_type i_sfr;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_rvalid;
  logic o_sfr_hit;
  logic o_can_activity_priority;
  logic [9:0] i_dir_tx;
  logic [9:0] o_tx_enable;
  cmc_event_type [9:0] i_evt;
  cmc_ctrl_type [9:0] o_ctrl;
  logic [7:0] exp_c [10];
  logic [7:0] exp_eip;
  logic [7:0] pend_data;
  logic pend_rd;
  logic [9:0] rdir;
  logic [31:0] seed;
  cmc_event_type [9:0] ev;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  cmc_msg_ctrl_regs #(.NUM_CENTERS(10)) dut (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sfr(i_sfr),
    .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_rvalid(o_sfr_rvalid),
    .o_sfr_hit(o_sfr_hit),
    .i_dir_tx(i_dir_tx),
    .i_evt(i_evt),
    .o_ctrl(o_ctrl),
    .o_tx_enable(o_tx_enable),
    .o_can_activity_priority(o_can_activity_priority)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Ceiling well above the roughly 850 cycles of the sequence
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic int idx_of(logic [7:0] a);
    if (a >= 8'hf3 && a <= 8'hf7) return int'(a - 8'hf3);
    if (a == CMC_ADDR_EIP) return 10;
    if (a >= 8'hfb) return int'(a - 8'hfb) + 5;
    return -1;
  endfunction

  function automatic logic [7:0] addr_of(int i);
    return (i < 5) ? 8'(8'hf3 + i) : 8'(8'hfb + i - 5);
  endfunction

  // Center 15 receives only, so its direction input is ignored
  function automatic logic txd(int i, logic [9:0] d);
    return d[i] && (i != 9);
  endfunction

  function automatic logic [7:0] nxt(logic [7:0] o, logic wr, logic [7:0] wd, logic tx,
                                     cmc_event_type e);
    logic [7:0] n;
    n = o;
    if (wr) begin
      n = {wd[7:4], o[3] & wd[3], wd[2], tx ? wd[1] : ((o[0] & ~wd[0]) ? 1'b0 : o[1]), wd[0]};
    end
    // Engine events judge by the bits as they stood before any write
    if (e.rx_stored && !tx) begin
      if (o[0]) n[1] = 1'b1;
      n[0] = 1'b1;
      if (o[5]) n[4] = 1'b1;
    end
    if (e.tx_done) begin
      n[2] = 1'b0;
      if (o[6] && tx) n[4] = 1'b1;
    end
    if (e.remote_req) begin
      n[3] = 1'b1;
      if (tx) n[2] = 1'b1;
    end
    return n;
  endfunction

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; outputs seen mid-cycle reflect all earlier cycles
  task op(input logic [7:0] a, input logic wr, input logic rd, input logic [7:0] wd,
          input logic [9:0] dir, input cmc_event_type [9:0] e);
    int k;
    k = idx_of(a);
    @(posedge i_clk);
    i_sfr <= '{addr: a, wr: wr, rd: rd, wdata: wd};
    i_dir_tx <= dir;
    i_evt <= e;
    @(negedge i_clk);
    chk_bit(o_sfr_hit, k >= 0);
    for (int g = 0; g < 10; g++) begin
      chk_byte(o_ctrl[g], exp_c[g]);
      chk_bit(o_tx_enable[g], exp_c[g][7] & exp_c[g][2] & ~(txd(g, dir) & exp_c[g][1]));
    end
    chk_bit(o_can_activity_priority, exp_eip[7]);
    chk_bit(o_sfr_rvalid, pend_rd);
    if (pend_rd) chk_byte(o_sfr_rdata, pend_data);
    pend_rd = rd;
    pend_data = (k < 0) ? 8'h00 : ((k == 10) ? exp_eip : exp_c[k]);
    if (wr && k == 10) exp_eip = wd;
    for (int g = 0; g < 10; g++) exp_c[g] = nxt(exp_c[g], wr && k == g, wd, txd(g, dir), e[g]);
  endtask

  task do_reset();
    @(posedge i_clk);
    i_reset <= 1'b1;
    i_sfr <= '0;
    i_evt <= '0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int g = 0; g < 10; g++) exp_c[g] = CMC_CTRL_RESET;
    exp_eip = CMC_EIP_RESET;
    pend_rd = 1'b0;
  endtask

  task wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    i_reset <= 1'b1;
    i_sfr <= '0;
    i_dir_tx <= '0;
    i_evt <= '0;
    rdir = '0;
    seed = 32'h7e2f_16a1;
    do_reset();
    for (int a = 8'hf0; a <= 8'hff; a++) op(8'(a), 1'b0, 1'b1, 8'h00, rdir, '0);
    op(8'h00, 1'b1, 1'b0, 8'hff, rdir, '0);
    op(8'hf9, 1'b1, 1'b1, 8'hff, rdir, '0);
    $display("test reset_decode done");
    op(CMC_ADDR_EIP, 1'b1, 1'b0, 8'h80, rdir, '0);
    op(CMC_ADDR_EIP, 1'b1, 1'b1, 8'h7f, rdir, '0);
    op(CMC_ADDR_EIP, 1'b0, 1'b1, 8'h00, rdir, '0);
    $display("test priority done");
    for (int g = 0; g < 10; g++) op(addr_of(g), 1'b1, 1'b1, 8'hff, 10'h3ff, '0);
    ev = '0;
    ev[2].remote_req = 1'b1;
    op(addr_of(2), 1'b1, 1'b0, 8'h00, 10'h3ff, ev);
    op(addr_of(2), 1'b0, 1'b1, 8'h00, 10'h3ff, '0);
    $display("test write_access done");
    for (int n = 0; n < 800; n++) begin
      seed = lfsr(seed);
      ev = '0;
      case (seed[5:4])
        2'd0: begin
          // Some writes meet an engine event on the same center
          if (seed[7]) ev[seed[3:0] % 10] = cmc_event_type'(seed[11:9]);
          op(addr_of(seed[3:0] % 10), 1'b1, seed[8], seed[31:24], rdir, ev);
        end
        2'd1: op(addr_of(seed[3:0] % 10), 1'b0, 1'b1, 8'h00, rdir, ev);
        2'd2: begin
          if (seed[7:6] == 2'd0) ev[seed[3:0] % 10].tx_done = 1'b1;
          if (seed[7:6] == 2'd1) ev[seed[3:0] % 10].rx_stored = 1'b1;
          if (seed[7:6] == 2'd2) ev[seed[3:0] % 10].remote_req = 1'b1;
          op(8'h00, 1'b0, 1'b0, 8'h00, rdir, ev);
        end
        default: begin
          rdir = seed[17:8];
          op(8'h00, 1'b0, 1'b0, 8'h00, rdir, ev);
        end
      endcase
    end
    $display("test random done");
    do_reset();
    for (int g = 0; g < 10; g++) op(addr_of(g), 1'b0, 1'b1, 8'h00, rdir, '0);
    op(CMC_ADDR_EIP, 1'b0, 1'b1, 8'h00, rdir, '0);
    op(8'h00, 1'b0, 1'b0, 8'h00, rdir, '0);
    $display("test mid_reset done");
    wrap_up();
  end
endmodule
